// ### hw/nvmac_pkg.sv
package nvmac_pkg;

  // Register byte addresses on the APB slave
  localparam logic [11:0] OFS_DATA_LOW = 12'h000;
  localparam logic [11:0] OFS_DATA_HIGH = 12'h004;
  localparam logic [11:0] OFS_ADDR_LOW = 12'h008;
  localparam logic [11:0] OFS_ADDR_HIGH = 12'h00C;
  localparam logic [11:0] OFS_CONTROL = 12'h010;
  localparam logic [11:0] OFS_UNLOCK = 12'h014;

  // Control field positions
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_PEN = 2;
  localparam int BIT_ERR = 3;
  localparam int BIT_FREE = 4;
  localparam int BIT_LATCH_ONLY_LOAD = 5;
  localparam int BIT_CONFIG_SPACE_SELECT = 6;
  localparam int BIT_PGD = 7;

  // Unlock pattern
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // Reset values
  localparam logic [7:0] RST_ADDR_LOW = 8'h00;
  localparam logic [6:0] RST_ADDR_HIGH = 7'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_HIGH_FILL = 8'h80;

  // Configuration space readable and writable windows
  localparam logic [14:0] CFG_ID_LAST = 15'h0003;
  localparam logic [14:0] CFG_DEVID = 15'h0006;
  localparam logic [14:0] CFG_WORD_LAST = 15'h0008;
  localparam logic [14:0] CFG_WRITE_LAST = 15'h0003;

  // Operation timing, in ns, and derived cycle counts at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 2000;
  localparam int ERASE_TIME_NS = 2000;
  localparam logic [15:0] PROG_CYCLES =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ERASE_CYCLES =
    16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Unlock detector states
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_GOT55 = 2'b01,
    UL_OPEN = 2'b10
  } nvmac_unlock_t;

  // Operation sequencer states
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_ERASE = 2'b01,
    OP_PROG = 2'b10
  } nvmac_op_t;

endpackage : nvmac_pkg

// ### hw/nvm_access_control_regs.sv
// Function
// RQ1 - Eight-bit data-low register, read and write
// RQ2 - Data-high holds six bits, top two zero
// RQ3 - Address-low register, eight bits, resets zero
// RQ4 - Address-high seven bits, bit seven reads one
// RQ5 - Bit seven picks flash over data EEPROM
// RQ6 - Bit six picks configuration and ID space
// RQ7 - Latch-only bit: trigger only loads latches
// RQ8 - Latch-only clear: load then program latches
// RQ9 - EEPROM ignores latch-only, always writes
// RQ10 - Erase bit selects erase, cleared when done
// RQ11 - EEPROM trigger does erase then write
// RQ12 - Error flag set on trigger attempts
// RQ13 - Enable bit gates all program and erase
// RQ14 - Write trigger self-timed, hardware clears it
// RQ15 - Software can only set write trigger
// RQ16 - Read trigger one cycle, set only
// RQ17 - Software writes 55h then AAh first
// RQ18 - Unlock register keeps nothing written
// RQ19 - Bad configuration read clears data pair
// RQ20 - Core stalls during flash erase or write
// RQ21 - Unlock must immediately precede the trigger
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module nvm_access_control_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory array port
  output logic [14:0] memAddr,
  output logic [13:0] memWdata,
  output logic memFlash,
  output logic memConfig,
  // Array strobes
  output logic memRead,
  output logic memLatch,
  output logic memErase,
  output logic memProgram,
  // Array read-back
  input wire logic [13:0] memRdata,
  // Core stall while flash is busy
  output logic coreStall
);

  typedef struct packed {
    // Software-visible registers
    logic [7:0] dataLow;
    logic [5:0] dataHigh;
    logic [7:0] addrLow;
    logic [6:0] addrHigh;
    logic [7:0] control;
    // Unlock detector and sequencer
    nvmac_pkg::nvmac_unlock_t unlock;
    nvmac_pkg::nvmac_op_t op;
    logic opEeprom;
    logic [15:0] timer;
    // Registered bus answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Array strobes and stall
    logic memRead;
    logic memLatch;
    logic memErase;
    logic memProgram;
    logic coreStall;
  } nvmac_state_t;

  nvmac_state_t state_reg;
  nvmac_state_t state_next;

  logic setup;
  logic wrAcc;
  logic rdAcc;
  logic [14:0] address;
  logic cfgReadable;
  logic cfgWritable;
  logic ctrlWrite;
  logic rdRequest;
  logic wrRequest;

  // Setup phase decode; each access answers on its second cycle
  assign setup = psel && !penable;
  assign wrAcc = setup && pwrite;
  assign rdAcc = setup && !pwrite;
  assign address = {state_reg.addrHigh, state_reg.addrLow};

  // Configuration space readable and writable windows
  assign cfgReadable = (address <= nvmac_pkg::CFG_ID_LAST) ||
    (address >= nvmac_pkg::CFG_DEVID &&
    address <= nvmac_pkg::CFG_WORD_LAST);
  assign cfgWritable = address <= nvmac_pkg::CFG_WRITE_LAST;

  // Control write in setup; its read bit and a write attempt's error flag win over hardware clears
  assign ctrlWrite = wrAcc && paddr == nvmac_pkg::OFS_CONTROL;
  assign rdRequest = ctrlWrite && pwdata[nvmac_pkg::BIT_RD] && !pwdata[nvmac_pkg::BIT_WR];
  assign wrRequest = ctrlWrite && pwdata[nvmac_pkg::BIT_WR];

  // Register, unlock and operation sequencing
  always_comb begin
    logic [7:0] wb;
    logic wrTrig;
    logic flashSel;
    logic cfgSel;
    logic idle;
    logic unlocked;
    logic enabled;
    logic eraseSel;
    logic latchSel;
    wb = pwdata[7:0];
    wrTrig = 1'b0;
    cfgSel = state_reg.control[nvmac_pkg::BIT_CONFIG_SPACE_SELECT];
    idle = state_reg.op == nvmac_pkg::OP_IDLE;
    unlocked = state_reg.unlock == nvmac_pkg::UL_OPEN;
    enabled = state_reg.control[nvmac_pkg::BIT_PEN];
    eraseSel = state_reg.control[nvmac_pkg::BIT_FREE];
    latchSel = state_reg.control[nvmac_pkg::BIT_LATCH_ONLY_LOAD];
    // Pulses default low, every register holds
    state_next = state_reg;
    state_next.pready = setup;
    state_next.pslverr = 1'b0;
    state_next.memRead = 1'b0;
    state_next.memLatch = 1'b0;
    state_next.memErase = 1'b0;
    state_next.memProgram = 1'b0;
    // Bit 6 overrides bit 7 when selecting the space
    flashSel = state_reg.control[nvmac_pkg::BIT_CONFIG_SPACE_SELECT] || state_reg.control[nvmac_pkg::BIT_PGD]; // RQ5 RQ6

    // Register reads
    if (rdAcc) begin
      unique case (paddr)
        nvmac_pkg::OFS_DATA_LOW: begin
          state_next.prdata = {24'h000000, state_reg.dataLow}; // RQ1
        end
        nvmac_pkg::OFS_DATA_HIGH: begin
          state_next.prdata = {26'h0, state_reg.dataHigh}; // RQ2
        end
        nvmac_pkg::OFS_ADDR_LOW: begin
          state_next.prdata = {24'h000000, state_reg.addrLow}; // RQ3
        end
        nvmac_pkg::OFS_ADDR_HIGH: begin
          state_next.prdata = {24'h000000, nvmac_pkg::ADDR_HIGH_FILL | {1'b0, state_reg.addrHigh}}; // RQ4
        end
        nvmac_pkg::OFS_CONTROL: begin
          state_next.prdata = {24'h000000, state_reg.control};
        end
        nvmac_pkg::OFS_UNLOCK: begin
          state_next.prdata = 32'h00000000; // RQ18
        end
        default: begin
          state_next.prdata = 32'h00000000;
          state_next.pslverr = 1'b1;
        end
      endcase
    end

    // Any access other than the pattern writes re-arms the detector
    if (setup &&
        !(wrAcc && (paddr == nvmac_pkg::OFS_UNLOCK ||
        (paddr == nvmac_pkg::OFS_CONTROL && wb[nvmac_pkg::BIT_WR])))) begin
      state_next.unlock = nvmac_pkg::UL_IDLE; // RQ21
    end

    // Register writes
    if (wrAcc) begin
      unique case (paddr)
        nvmac_pkg::OFS_DATA_LOW: begin
          state_next.dataLow = wb; // RQ1
        end
        nvmac_pkg::OFS_DATA_HIGH: begin
          state_next.dataHigh = wb[5:0]; // RQ2
        end
        nvmac_pkg::OFS_ADDR_LOW: begin
          state_next.addrLow = wb; // RQ3
        end
        nvmac_pkg::OFS_ADDR_HIGH: begin
          state_next.addrHigh = wb[6:0]; // RQ4
        end
        nvmac_pkg::OFS_UNLOCK: begin
          // Pattern only drives the detector, no value is stored
          if (state_reg.unlock == nvmac_pkg::UL_IDLE &&
              wb == nvmac_pkg::UNLOCK_FIRST) begin
            state_next.unlock = nvmac_pkg::UL_GOT55; // RQ17 RQ18
          end else if (state_reg.unlock == nvmac_pkg::UL_GOT55 &&
              wb == nvmac_pkg::UNLOCK_SECOND) begin
            state_next.unlock = nvmac_pkg::UL_OPEN; // RQ17
          end else begin
            state_next.unlock = nvmac_pkg::UL_IDLE; // RQ21
          end
        end
        nvmac_pkg::OFS_CONTROL: begin
          // Plain bits; busy operation freezes space selection
          if (state_reg.op == nvmac_pkg::OP_IDLE) begin
            state_next.control[7:4] = wb[7:4]; // RQ5 RQ6 RQ7 RQ10
          end
          // Flag follows the written value unless the write trigger is set
          state_next.control[nvmac_pkg::BIT_ERR] = wb[nvmac_pkg::BIT_ERR];
          state_next.control[nvmac_pkg::BIT_PEN] = wb[nvmac_pkg::BIT_PEN]; // RQ13
          // Trigger bits are set-only: zero written leaves them
          if (wb[nvmac_pkg::BIT_WR]) begin
            state_next.control[nvmac_pkg::BIT_ERR] = 1'b1; // RQ12
            wrTrig = 1'b1; // RQ15
          end
          if (wb[nvmac_pkg::BIT_RD] && !wb[nvmac_pkg::BIT_WR]) begin
            state_next.control[nvmac_pkg::BIT_RD] = 1'b1; // RQ16
          end
          // Any control write closes the unlock window
          state_next.unlock = nvmac_pkg::UL_IDLE; // RQ21
        end
        default: begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end

    // Read completes the cycle after it was set
    if (state_reg.control[nvmac_pkg::BIT_RD]) begin
      // A new read set in this same cycle stands
      state_next.control[nvmac_pkg::BIT_RD] = rdRequest; // RQ16
      state_next.memRead = 1'b1;
      if (cfgSel && !cfgReadable) begin
        // Hole in configuration space clears the pair
        state_next.dataLow = 8'h00; // RQ19
        state_next.dataHigh = 6'h00; // RQ19
      end else begin
        state_next.dataLow = memRdata[7:0];
        if (flashSel) begin
          state_next.dataHigh = memRdata[13:8];
        end else begin
          // Data EEPROM words are one byte wide
          state_next.dataHigh = 6'h00;
        end
      end
    end

    // Trigger start: needs idle, unlock just done and enable set
    if (wrTrig &&
        idle &&
        unlocked && // RQ17 RQ21
        wb[nvmac_pkg::BIT_PEN] &&
        enabled) begin // RQ13
      if (!flashSel) begin
        // Data EEPROM: latch-only and erase bits ignored
        state_next.op = nvmac_pkg::OP_ERASE; // RQ9 RQ11
        state_next.opEeprom = 1'b1;
        state_next.timer = nvmac_pkg::ERASE_CYCLES;
        state_next.memErase = 1'b1;
        state_next.control[nvmac_pkg::BIT_WR] = 1'b1; // RQ14
      end else if (cfgSel && !cfgWritable) begin
        // Only user ID words take writes; the rest stay read-only
        state_next.control[nvmac_pkg::BIT_WR] = 1'b0; // Read-only word, refused
      end else if (eraseSel) begin
        // Flash or configuration row erase, core held meanwhile
        state_next.op = nvmac_pkg::OP_ERASE; // RQ10
        state_next.opEeprom = 1'b0;
        state_next.timer = nvmac_pkg::ERASE_CYCLES;
        state_next.memErase = 1'b1;
        state_next.coreStall = 1'b1; // RQ20
        state_next.control[nvmac_pkg::BIT_WR] = 1'b1; // RQ14
      end else if (latchSel) begin
        // Latch update only, finishes at once without error
        state_next.memLatch = 1'b1; // RQ7
        state_next.control[nvmac_pkg::BIT_ERR] = 1'b0;
      end else begin
        // Load the last word, then program all latches
        state_next.memLatch = 1'b1; // RQ8
        state_next.op = nvmac_pkg::OP_PROG; // RQ8
        state_next.opEeprom = 1'b0;
        state_next.timer = nvmac_pkg::PROG_CYCLES;
        state_next.memProgram = 1'b1;
        state_next.coreStall = 1'b1; // RQ20
        state_next.control[nvmac_pkg::BIT_WR] = 1'b1; // RQ14
      end
    end

    // Self-timed sequencer
    unique case (state_reg.op)
      nvmac_pkg::OP_IDLE: begin
        // Nothing runs; triggers are taken above
      end
      nvmac_pkg::OP_ERASE: begin
        if (state_reg.timer > 16'h0001) begin
          state_next.timer = state_reg.timer - 16'h0001;
        // Data EEPROM goes on to its write cycle
        end else if (state_reg.opEeprom) begin
          state_next.op = nvmac_pkg::OP_PROG; // RQ11
          state_next.timer = nvmac_pkg::PROG_CYCLES;
          state_next.memProgram = 1'b1;
        end else begin
          state_next.op = nvmac_pkg::OP_IDLE;
          state_next.control[nvmac_pkg::BIT_FREE] = 1'b0; // RQ10
          state_next.control[nvmac_pkg::BIT_WR] = 1'b0; // RQ14
          // A trigger attempt in this same cycle keeps the flag set
          state_next.control[nvmac_pkg::BIT_ERR] = wrRequest; // RQ12
          state_next.coreStall = 1'b0; // RQ20
        end
      end
      nvmac_pkg::OP_PROG: begin
        if (state_reg.timer > 16'h0001) begin
          state_next.timer = state_reg.timer - 16'h0001;
        end else begin
          state_next.op = nvmac_pkg::OP_IDLE;
          state_next.control[nvmac_pkg::BIT_WR] = 1'b0; // RQ14
          // A trigger attempt in this same cycle keeps the flag set
          state_next.control[nvmac_pkg::BIT_ERR] = wrRequest; // RQ12
          state_next.coreStall = 1'b0; // RQ20
        end
      end
      default: begin
        // Unused code falls back to idle
        state_next.op = nvmac_pkg::OP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // Constants only; an operation in flight is dropped
      state_reg.dataLow <= nvmac_pkg::RST_DATA;
      state_reg.dataHigh <= 6'h00;
      state_reg.addrLow <= nvmac_pkg::RST_ADDR_LOW;
      state_reg.addrHigh <= nvmac_pkg::RST_ADDR_HIGH;
      state_reg.control <= nvmac_pkg::RST_CONTROL;
      state_reg.unlock <= nvmac_pkg::UL_IDLE;
      state_reg.op <= nvmac_pkg::OP_IDLE;
      state_reg.opEeprom <= 1'b0;
      state_reg.timer <= 16'h0000;
      state_reg.prdata <= 32'h00000000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.memRead <= 1'b0;
      state_reg.memLatch <= 1'b0;
      state_reg.memErase <= 1'b0;
      state_reg.memProgram <= 1'b0;
      state_reg.coreStall <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;

  // Array address, data and space select
  assign memAddr = {state_reg.addrHigh, state_reg.addrLow};
  assign memWdata = {state_reg.dataHigh, state_reg.dataLow};
  assign memFlash = state_reg.control[nvmac_pkg::BIT_PGD];
  assign memConfig = state_reg.control[nvmac_pkg::BIT_CONFIG_SPACE_SELECT];

  // Array strobes and core stall
  assign memRead = state_reg.memRead;
  assign memLatch = state_reg.memLatch;
  assign memErase = state_reg.memErase;
  assign memProgram = state_reg.memProgram;
  assign coreStall = state_reg.coreStall;

endmodule : nvm_access_control_regs

`default_nettype wire

// ### test/nvmac_chk.sv
`timescale 1ns/1ps
`default_nettype none

module nvmac_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Array side
  input wire logic [14:0] memAddr,
  input wire logic [13:0] memWdata,
  input wire logic memFlash,
  input wire logic memConfig,
  input wire logic memRead,
  input wire logic memLatch,
  input wire logic memErase,
  input wire logic memProgram,
  input wire logic coreStall
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Setup phase and read answer qualifiers
  logic setup;
  logic rdAns;
  assign setup = psel && !penable;
  assign rdAns = pready && !pwrite;

  // Bus timing: one answer, one cycle after setup
  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_data_low_read: assert property (rdAns && paddr == nvmac_pkg::OFS_DATA_LOW |-> prdata == {24'h0, memWdata[7:0]}) else $error("data low mismatch");
  a_data_high_read: assert property (rdAns && paddr == nvmac_pkg::OFS_DATA_HIGH |-> prdata == {26'h0, memWdata[13:8]}) else $error("data high mismatch");
  a_addr_low_load: assert property (setup && pwrite && paddr == nvmac_pkg::OFS_ADDR_LOW |=> memAddr[7:0] == $past(pwdata[7:0])) else $error("address low not loaded");
  a_addr_high_read: assert property (rdAns && paddr == nvmac_pkg::OFS_ADDR_HIGH |-> prdata == {24'h0, 1'b1, memAddr[14:8]}) else $error("address high mismatch");
  a_space_select: assert property (rdAns && paddr == nvmac_pkg::OFS_CONTROL |-> prdata[31:6] == {24'h0, memFlash, memConfig}) else $error("space bits mismatch");
  a_disabled_trigger: assert property (setup && pwrite && paddr == nvmac_pkg::OFS_CONTROL && pwdata[2:1] == 2'b01 |=> (!memLatch && !memErase && !memProgram) [*3]) else $error("operation without enable");
  a_read_pulse: assert property (memRead |=> !memRead) else $error("read pulse too long");
  a_unlock_empty: assert property (rdAns && paddr == nvmac_pkg::OFS_UNLOCK |-> prdata == 32'h0) else $error("unlock kept data");
  a_stall_flash: assert property (coreStall |-> memFlash || memConfig) else $error("stall outside flash");
endmodule : nvmac_chk

`default_nettype wire

// ### test/nvm_access_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module nvm_access_control_regs_bench;
  // Design connections
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, coreStall, e;
  logic memLatch, memErase, memProgram;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [13:0] memRdata;
  int numErrors = 0, comparisons = 0, nLatch = 0, nProg = 0, nErase = 0, nStall = 0;

  nvm_access_control_regs uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memAddr(), .memWdata(), .memFlash(), .memConfig(),
    .memRead(), .memLatch(memLatch), .memErase(memErase), .memProgram(memProgram),
    .memRdata(memRdata), .coreStall(coreStall));

  // Clock at 20 MHz
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Pulses last one cycle, so count them as they pass
  always @(posedge ref_clk) begin
    if (memLatch === 1'b1) nLatch <= nLatch + 1;
    if (memProgram === 1'b1) nProg <= nProg + 1;
    if (memErase === 1'b1) nErase <= nErase + 1;
    if (coreStall === 1'b1) nStall <= nStall + 1;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so strobes never toggle twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    xfer(1'b0, a, 8'h00);
    chk(n, x, r);
  endtask : rd

  // Unlock, trigger, then wait for the self-timed end
  task automatic op(input logic [7:0] c, input logic [7:0] fin, input int la, input int pe,
    input int er, input int st);
    int p0, e0, s0, l0, n;
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, c & 8'hFD);
    p0 = nProg; e0 = nErase; s0 = nStall; l0 = nLatch;
    xfer(1'b1, nvmac_pkg::OFS_UNLOCK, 8'h55);
    xfer(1'b1, nvmac_pkg::OFS_UNLOCK, 8'hAA);
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, c);
    if (er + st > 0) begin
      xfer(1'b1, nvmac_pkg::OFS_CONTROL, c & 8'hFD);
      rd(nvmac_pkg::OFS_CONTROL, {24'h0, (c & 8'hF6) | 8'h02}, "busy");
    end
    n = 0;
    do begin
      xfer(1'b0, nvmac_pkg::OFS_CONTROL, 8'h00);
      n++;
    end while (r[1] !== 1'b0 && n < 100);
    chk("control", {24'h0, fin}, r);
    chk("programs", 32'(pe), 32'(nProg - p0));
    chk("erases", 32'(er), 32'(nErase - e0));
    chk("stall", 32'(st), 32'(nStall - s0));
    if (la >= 0) chk("latches", 32'(la), 32'(nLatch - l0));
    $display("operation %h done", c);
  endtask : op

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    print_verdict();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    memRdata = 14'h0000;
    nrst = 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // Reset values, widths and unmapped space
    rd(nvmac_pkg::OFS_ADDR_LOW, 32'h00, "addr low");
    rd(nvmac_pkg::OFS_ADDR_HIGH, 32'h80, "addr high");
    rd(nvmac_pkg::OFS_CONTROL, 32'h00, "control reset");
    xfer(1'b1, nvmac_pkg::OFS_DATA_LOW, 8'hFF);
    rd(nvmac_pkg::OFS_DATA_LOW, 32'hFF, "data low");
    xfer(1'b1, nvmac_pkg::OFS_DATA_HIGH, 8'hFF);
    rd(nvmac_pkg::OFS_DATA_HIGH, 32'h3F, "data high");
    xfer(1'b1, nvmac_pkg::OFS_ADDR_HIGH, 8'hFF);
    rd(nvmac_pkg::OFS_ADDR_HIGH, 32'hFF, "addr high");
    xfer(1'b1, nvmac_pkg::OFS_UNLOCK, 8'h5A);
    rd(nvmac_pkg::OFS_UNLOCK, 32'h00, "unlock");
    rd(12'h018, 32'h00, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
    $display("registers done");
    // Triggers refused without a clean unlock
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, 8'h86);
    rd(nvmac_pkg::OFS_CONTROL, 32'h8C, "no unlock");
    xfer(1'b1, nvmac_pkg::OFS_UNLOCK, 8'h55);
    rd(nvmac_pkg::OFS_ADDR_LOW, 32'h00, "addr low");
    xfer(1'b1, nvmac_pkg::OFS_UNLOCK, 8'hAA);
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, 8'h86);
    rd(nvmac_pkg::OFS_CONTROL, 32'h8C, "broken unlock");
    $display("refusals done");
    // Self-timed operations of every kind
    op(8'h86, 8'h84, 1, 1, 0, nvmac_pkg::PROG_CYCLES);
    op(8'hA6, 8'hA4, 1, 0, 0, 0);
    op(8'h26, 8'h24, -1, 1, 1, 0);
    op(8'h96, 8'h84, 0, 0, 1, nvmac_pkg::ERASE_CYCLES);
    op(8'h82, 8'h88, 0, 0, 0, 0);
    // Reads from flash and from a hole in configuration space
    memRdata <= 14'h1ABC;
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, 8'h81);
    rd(nvmac_pkg::OFS_DATA_LOW, 32'hBC, "read low");
    rd(nvmac_pkg::OFS_DATA_HIGH, 32'h1A, "read high");
    xfer(1'b0, nvmac_pkg::OFS_CONTROL, 8'h00);
    chk("read bit", 32'h0, {31'h0, r[0]});
    xfer(1'b1, nvmac_pkg::OFS_ADDR_HIGH, 8'h00);
    xfer(1'b1, nvmac_pkg::OFS_ADDR_LOW, 8'h05);
    xfer(1'b1, nvmac_pkg::OFS_CONTROL, 8'h41);
    rd(nvmac_pkg::OFS_DATA_LOW, 32'h00, "hole low");
    rd(nvmac_pkg::OFS_DATA_HIGH, 32'h00, "hole high");
    $display("reads done");
    print_verdict();
  end
endmodule : nvm_access_control_regs_bench

bind nvm_access_control_regs nvmac_chk chk (.*);

`default_nettype wire
